/* rtl/mlu_line_usart.sv */
// Transmit FIFO, line transmit USART and the line settings it obeys
`timescale 1ns/10ps

// ****************************************************************
// Character FIFO
// ****************************************************************
module mlu_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;
  logic ready_reg;

  assign in_ready = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign do_wr = clk_en && in_valid && in_ready;
  assign do_rd = clk_en && out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (do_wr)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
      if (do_wr && !do_rd)
      begin
        count_reg <= count_reg + 1'b1;
        ready_reg <= (count_reg != (AW+1)'(D-1));
      end
      else if (do_rd && !do_wr)
      begin
        count_reg <= count_reg - 1'b1;
        ready_reg <= 1'b1;
      end
    end
  end
endmodule

module mlu_line_usart
  import mlu_pkg::*;
#(
  parameter int unsigned CLK_FREQ = CLK_HZ,
  parameter int unsigned SEC_CYC = RTS_UNIT_CYC,
  parameter int unsigned BRK_CYC = BRK_UNIT_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  // Setting register port
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Transmit character port
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic tx_pattern_en,
  // Transmit status and line
  output logic tx_data_ready,
  output logic tx_underflow,
  output logic tx_line,
  // Decoded settings
  output logic [4:0] tx_atten_hdb,
  output logic [4:0] rx_atten_hdb,
  output logic [3:0] rx_data_bits,
  output logic rx_parity_en,
  output logic [1:0] rx_overspeed,
  output logic rx_sync,
  output logic [3:0] line_std,
  output logic std_reserved,
  // Request-to-send supervision
  input wire logic data_mode,
  input wire logic request_to_send_pin,
  output logic cmd_return,
  // Timed break recall
  input wire logic break_start,
  output logic line_break,
  output logic break_done,
  // Result codes
  input wire logic result_stb,
  input wire mlu_result_e result_sel,
  output logic [3:0] result_code,
  output logic result_valid
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [4:0] atten(input logic [2:0] code);
    logic [4:0] steps;
    steps = {2'b00, GAIN_MAX_CODE - code};
    return 5'((steps << 1) + steps);
  endfunction

  function automatic logic [31:0] bit_cycles(input logic [3:0] s);
    case (s)
      STD_V22BIS: return 32'(CLK_FREQ / 2400);
      STD_V23_TX75: return 32'(CLK_FREQ / 75);
      STD_B202_TX150: return 32'(CLK_FREQ / 150);
      STD_V22, STD_V23_TX1200, STD_B212A, STD_B202_TX1200:
        return 32'(CLK_FREQ / 1200);
      default: return 32'(CLK_FREQ / 300);
    endcase
  endfunction

  // ****************************************************************
  // Setting registers
  // ****************************************************************
  logic [7:0] tx_cfg_reg;
  logic [7:0] rx_cfg_reg;
  logic [7:0] std_reg;
  logic [7:0] rts_tmo_reg;
  logic [7:0] brk_reg;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_cfg_reg <= TX_CFG_RST;
      rx_cfg_reg <= RX_CFG_RST;
      std_reg <= STD_RST;
      rts_tmo_reg <= RTS_TMO_RST;
      brk_reg <= BRK_RST;
      cfg_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      if (cfg_wr)
      begin
        case (cfg_addr)
          REG_TX_CFG: tx_cfg_reg <= cfg_wdata;
          REG_RX_CFG: rx_cfg_reg <= cfg_wdata;
          REG_STD: std_reg <= cfg_wdata;
          REG_RTS_TMO: rts_tmo_reg <= cfg_wdata;
          REG_BRK: brk_reg <= cfg_wdata;
          default: ;
        endcase
      end
      case (cfg_addr)
        REG_TX_CFG: cfg_rdata <= tx_cfg_reg;
        REG_RX_CFG: cfg_rdata <= rx_cfg_reg;
        REG_STD: cfg_rdata <= std_reg;
        REG_RTS_TMO: cfg_rdata <= rts_tmo_reg;
        REG_BRK: cfg_rdata <= brk_reg;
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

  // Transmit field decode
  logic [1:0] tx_fmt;
  logic tx_is_sync;
  logic tx_par_en;
  logic [3:0] tx_nbits;
  logic tx_two_stop;
  assign tx_fmt = tx_cfg_reg[FMT_LSB +: 2];
  assign tx_is_sync = (tx_fmt == FMT_SYNC) || tx_pattern_en;
  assign tx_par_en = (tx_fmt == FMT_ODD_PAR);
  assign tx_nbits = tx_is_sync ? SYNC_BITS :
    MIN_DATA_BITS + {2'b00, tx_cfg_reg[FRM_LSB+1 +: 2]};
  assign tx_two_stop = tx_cfg_reg[FRM_LSB];

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_atten_hdb <= '0;
      rx_atten_hdb <= '0;
      rx_data_bits <= '0;
      rx_parity_en <= 1'b0;
      rx_overspeed <= '0;
      rx_sync <= 1'b0;
      line_std <= '0;
      std_reserved <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_atten_hdb <= atten(tx_cfg_reg[GAIN_LSB +: 3]);
      rx_atten_hdb <= atten(rx_cfg_reg[GAIN_LSB +: 3]);
      rx_data_bits <= MIN_DATA_BITS + {2'b00, rx_cfg_reg[FRM_LSB+1 +: 2]};
      rx_parity_en <= rx_cfg_reg[FRM_LSB];
      rx_overspeed <= rx_cfg_reg[FMT_LSB +: 2];
      rx_sync <= (rx_cfg_reg[FMT_LSB +: 2] == FMT_SYNC);
      line_std <= std_reg[STD_LSB +: 4];
      std_reserved <= (std_reg[STD_LSB +: 4] == STD_RESERVED) ||
        (std_reg[STD_LSB +: 4] > STD_B103);
    end
  end

  // ****************************************************************
  // Transmit path: FIFO, data register, buffer, serialiser
  // ****************************************************************
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic [7:0] buf_reg;
  logic [7:0] sh_reg;
  logic par_reg;
  logic [3:0] bit_cnt_reg;
  logic stop_cnt_reg;
  logic [31:0] baud_cnt_reg;
  logic bit_tick;
  logic boundary;
  logic load;
  mlu_tx_state_e state_reg;

  mlu_fifo #(.W(8), .D(DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(!hold_full_reg),
    .out_data(fifo_data)
  );

  assign load = fifo_valid && !hold_full_reg;
  assign bit_tick = (baud_cnt_reg == '0);
  assign boundary = bit_tick && ((state_reg == TX_IDLE) ||
    (state_reg == TX_DATA && tx_is_sync && bit_cnt_reg == tx_nbits) ||
    (state_reg == TX_STOP && stop_cnt_reg == tx_two_stop));

  // Bit clock runs freely so idle stop level keeps whole-bit timing
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      baud_cnt_reg <= '0;
    else if (clk_en)
      baud_cnt_reg <= bit_tick ? bit_cycles(std_reg[STD_LSB +: 4]) - 1 :
        baud_cnt_reg - 1;
  end

  // Data register and its status flags
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      hold_reg <= '0;
      hold_full_reg <= 1'b0;
      tx_data_ready <= 1'b0;
      tx_underflow <= 1'b0;
    end
    else if (clk_en)
    begin
      if (load)
      begin
        hold_reg <= fifo_data;
        hold_full_reg <= 1'b1;
        tx_data_ready <= 1'b0;
        tx_underflow <= 1'b0;
      end
      if (boundary && hold_full_reg)
      begin
        hold_full_reg <= 1'b0;
        tx_data_ready <= 1'b1;
      end
      if (boundary && !hold_full_reg && !tx_pattern_en)
        tx_underflow <= 1'b1;
    end
  end

  // Serialiser
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= TX_IDLE;
      buf_reg <= '0;
      sh_reg <= '0;
      par_reg <= 1'b0;
      bit_cnt_reg <= '0;
      stop_cnt_reg <= 1'b0;
      tx_line <= 1'b1;
    end
    else if (clk_en && bit_tick)
    begin
      if (boundary)
      begin
        if (hold_full_reg)
          buf_reg <= hold_reg;
        if (!hold_full_reg && !tx_is_sync)
        begin
          state_reg <= TX_IDLE;
          tx_line <= 1'b1;
        end
        else if (tx_is_sync)
        begin
          tx_line <= hold_full_reg ? hold_reg[0] : buf_reg[0];
          sh_reg <= (hold_full_reg ? hold_reg : buf_reg) >> 1;
          bit_cnt_reg <= 4'h1;
          state_reg <= TX_DATA;
        end
        else
        begin
          tx_line <= 1'b0;
          state_reg <= TX_START;
        end
      end
      else
      begin
        case (state_reg)
          TX_START:
          begin
            tx_line <= buf_reg[0];
            sh_reg <= buf_reg >> 1;
            bit_cnt_reg <= 4'h1;
            // Parity over only the bits sent, framing never from data
            par_reg <= ~^(buf_reg & 8'(8'hFF >> (SYNC_BITS - tx_nbits)));
            state_reg <= TX_DATA;
          end
          TX_DATA:
          begin
            if (bit_cnt_reg != tx_nbits)
            begin
              tx_line <= sh_reg[0];
              sh_reg <= sh_reg >> 1;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (tx_par_en)
            begin
              tx_line <= par_reg;
              state_reg <= TX_PAR;
            end
            else
            begin
              tx_line <= 1'b1;
              stop_cnt_reg <= 1'b0;
              state_reg <= TX_STOP;
            end
          end
          TX_PAR:
          begin
            tx_line <= 1'b1;
            stop_cnt_reg <= 1'b0;
            state_reg <= TX_STOP;
          end
          TX_STOP:
            stop_cnt_reg <= 1'b1;
          default:
          begin
            state_reg <= TX_IDLE;
            tx_line <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Request-to-send qualification
  // ****************************************************************
  logic rts_level_reg;
  logic [31:0] sec_cyc_reg;
  logic [7:0] sec_cnt_reg;

  // Pin change must persist; any bounce back restarts the wait
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rts_level_reg <= 1'b1;
      sec_cyc_reg <= '0;
      sec_cnt_reg <= '0;
      cmd_return <= 1'b0;
    end
    else if (clk_en)
    begin
      cmd_return <= 1'b0;
      if (!data_mode || rts_tmo_reg == 8'h00 ||
          request_to_send_pin == rts_level_reg)
      begin
        rts_level_reg <= request_to_send_pin;
        sec_cyc_reg <= '0;
        sec_cnt_reg <= '0;
      end
      else if (sec_cnt_reg == rts_tmo_reg)
      begin
        rts_level_reg <= request_to_send_pin;
        cmd_return <= 1'b1;
        sec_cnt_reg <= '0;
      end
      else if (sec_cyc_reg == SEC_CYC - 1)
      begin
        sec_cyc_reg <= '0;
        sec_cnt_reg <= sec_cnt_reg + 8'h01;
      end
      else
        sec_cyc_reg <= sec_cyc_reg + 1;
    end
  end

  // ****************************************************************
  // Timed break recall and result codes
  // ****************************************************************
  logic [31:0] brk_cyc_reg;
  logic [7:0] brk_cnt_reg;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      line_break <= 1'b0;
      break_done <= 1'b0;
      brk_cyc_reg <= '0;
      brk_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      break_done <= 1'b0;
      if (!line_break)
      begin
        line_break <= break_start;
        brk_cyc_reg <= '0;
        brk_cnt_reg <= '0;
      end
      else if (brk_cnt_reg == brk_reg)
      begin
        line_break <= 1'b0;
        break_done <= 1'b1;
      end
      else if (brk_cyc_reg == BRK_CYC - 1)
      begin
        brk_cyc_reg <= '0;
        brk_cnt_reg <= brk_cnt_reg + 8'h01;
      end
      else
        brk_cyc_reg <= brk_cyc_reg + 1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      result_code <= RES_OK;
      result_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      result_valid <= result_stb;
      if (result_stb)
        result_code <= result_sel;
    end
  end

endmodule

/* rtl/mlu_pkg.sv */
// Constants and types for the modem line transmit USART and its settings
package mlu_pkg;

  // Setting register numbers
  localparam logic [7:0] REG_TX_CFG = 8'h19;
  localparam logic [7:0] REG_RX_CFG = 8'h1A;
  localparam logic [7:0] REG_STD = 8'h1B;
  localparam logic [7:0] REG_RTS_TMO = 8'h1C;
  localparam logic [7:0] REG_BRK = 8'h1D;

  // Reset values
  localparam logic [7:0] TX_CFG_RST = 8'hB0;
  localparam logic [7:0] RX_CFG_RST = 8'h30;
  localparam logic [7:0] STD_RST = 8'h00;
  localparam logic [7:0] RTS_TMO_RST = 8'h00;
  localparam logic [7:0] BRK_RST = 8'h1E;

  // Field positions
  localparam int GAIN_LSB = 0;
  localparam int FRM_LSB = 3;
  localparam int FMT_LSB = 6;
  localparam int STD_LSB = 4;

  // Gain steps in half-dB, top code is 0 dB
  localparam logic [2:0] GAIN_MAX_CODE = 3'h7;
  localparam logic [4:0] GAIN_STEP_HDB = 5'h03;

  // Framing
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [1:0] FMT_ODD_PAR = 2'h0;
  localparam logic [1:0] FMT_NO_PAR = 2'h1;
  localparam logic [1:0] FMT_SYNC = 2'h3;

  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RTS_UNIT_MS = 1000;
  localparam int unsigned BRK_UNIT_MS = 10;
  localparam int unsigned RTS_UNIT_CYC = CLK_HZ / 1000 * RTS_UNIT_MS;
  localparam int unsigned BRK_UNIT_CYC = CLK_HZ / 1000 * BRK_UNIT_MS;

  localparam int FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    STD_V22BIS = 4'h0, STD_V22 = 4'h1, STD_V23_TX75 = 4'h2,
    STD_V23_TX1200 = 4'h3, STD_RESERVED = 4'h4, STD_V21 = 4'h5,
    STD_B212A = 4'h6, STD_B202_TX150 = 4'h7, STD_B202_TX1200 = 4'h8,
    STD_B103 = 4'h9
  } mlu_std_e;

  typedef enum logic [3:0] {
    RES_OK = 4'h0, RES_CONNECT = 4'h1, RES_RING = 4'h2,
    RES_NO_CARRIER = 4'h3, RES_ERROR = 4'h4, RES_NO_DIAL_TONE = 4'h5,
    RES_BUSY = 4'h6, RES_CONNECT_2400 = 4'h7, RES_CONNECT_1200 = 4'h8,
    RES_DUAL_TONE = 4'h9, RES_CONNECT_300 = 4'hA, RES_CONNECT_1200_75 = 4'hB,
    RES_CONNECT_75_1200 = 4'hC, RES_CONNECT_1200_150 = 4'hD,
    RES_CONNECT_150_1200 = 4'hE, RES_UNIMPLEMENTED = 4'hF
  } mlu_result_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR = 3'b011, TX_STOP = 3'b100
  } mlu_tx_state_e;

endpackage

/* verification/mlu_line_usart_checker.sv */
// Port assertions for the line transmit USART
`timescale 1ns/10ps
module mlu_line_usart_checker
  import mlu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  // Settings
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [4:0] tx_atten_hdb,
  input wire logic [4:0] rx_atten_hdb,
  input wire logic [3:0] rx_data_bits,
  input wire logic rx_parity_en,
  input wire logic [1:0] rx_overspeed,
  input wire logic rx_sync,
  input wire logic [3:0] line_std,
  input wire logic std_reserved,
  // Line and status
  input wire logic tx_pattern_en,
  input wire logic tx_data_ready,
  input wire logic tx_underflow,
  input wire logic tx_line,
  // Break and results
  input wire logic break_start,
  input wire logic line_break,
  input wire logic break_done,
  input wire logic result_stb,
  input wire mlu_result_e result_sel,
  input wire logic [3:0] result_code,
  input wire logic result_valid
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Shadow of the transmit format, decoded outputs do not expose it
  logic [1:0] fmt_reg;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fmt_reg <= 2'h2;
    else if (clk_en && cfg_wr && cfg_addr == REG_TX_CFG)
      fmt_reg <= cfg_wdata[7:6];
  end

  sequence s_wr(logic [7:0] a);
    clk_en && cfg_wr && cfg_addr == a ##1 clk_en;
  endsequence

  property p_tx_gain;
    s_wr(REG_TX_CFG) |=>
      tx_atten_hdb == 5'(3 * (7 - $past(cfg_wdata[2:0], 2)));
  endproperty
  property p_rx_gain;
    s_wr(REG_RX_CFG) |=>
      rx_atten_hdb == 5'(3 * (7 - $past(cfg_wdata[2:0], 2)));
  endproperty
  property p_rx_frame;
    s_wr(REG_RX_CFG) |=> rx_data_bits == 4'(5 + $past(cfg_wdata[5:4], 2))
      && rx_parity_en == $past(cfg_wdata[3], 2)
      && rx_overspeed == $past(cfg_wdata[7:6], 2)
      && rx_sync == ($past(cfg_wdata[7:6], 2) == 2'h3);
  endproperty
  property p_std;
    s_wr(REG_STD) |=> line_std == $past(cfg_wdata[7:4], 2)
      && std_reserved == ($past(cfg_wdata[7:4], 2) == 4'h4
      || $past(cfg_wdata[7:4], 2) > 4'h9);
  endproperty
  property p_start;
    $rose(tx_data_ready) && fmt_reg != FMT_SYNC && !tx_pattern_en
      |-> !tx_line;
  endproperty
  property p_underflow;
    $rose(tx_underflow) && fmt_reg != FMT_SYNC && !tx_pattern_en
      |-> tx_line [*2];
  endproperty
  property p_break_on;
    clk_en && break_start && !line_break |=> line_break;
  endproperty
  property p_break_end;
    $fell(line_break) |-> break_done;
  endproperty
  property p_result;
    clk_en && result_stb |=>
      result_valid && result_code == $past(result_sel);
  endproperty

  a_tx_gain: assert property (p_tx_gain)
    else $error("tx attenuation wrong");
  a_rx_gain: assert property (p_rx_gain)
    else $error("rx attenuation wrong");
  a_rx_frame: assert property (p_rx_frame)
    else $error("receive framing decode wrong");
  a_std: assert property (p_std)
    else $error("line standard decode wrong");
  a_start: assert property (p_start)
    else $error("no low start bit");
  a_underflow: assert property (p_underflow)
    else $error("line not at stop level during underflow");
  a_break_on: assert property (p_break_on)
    else $error("break request did not break the line");
  a_break_end: assert property (p_break_end)
    else $error("break ended without done pulse");
  a_result: assert property (p_result)
    else $error("result code not reported");

  c_underflow: cover property ($rose(tx_underflow));
  c_break: cover property ($fell(line_break));
  c_sync: cover property ($rose(tx_data_ready) && fmt_reg == FMT_SYNC);
endmodule

bind mlu_line_usart mlu_line_usart_checker mlu_line_usart_checker_i (
  .clock, .rstn, .clk_en, .cfg_wr, .cfg_addr, .cfg_wdata,
  .tx_atten_hdb, .rx_atten_hdb, .rx_data_bits, .rx_parity_en,
  .rx_overspeed, .rx_sync, .line_std, .std_reserved, .tx_pattern_en,
  .tx_data_ready, .tx_underflow, .tx_line, .break_start, .line_break,
  .break_done, .result_stb, .result_sel, .result_code, .result_valid
);

/* verification/mlu_remote_rx.sv */
// Remote modem model that decodes start-stop characters off the line
`timescale 1ns/10ps
module mlu_remote_rx #(
  parameter int BIT_CYC = 10
) (
  // Clock and line
  input wire logic clock,
  input wire logic en,
  input wire logic tx_line,
  // Expected framing
  input wire logic [3:0] nbits,
  input wire logic par_en,
  // Decoded character
  output logic [7:0] rx_byte,
  output logic rx_par,
  output logic stop_ok,
  output int rx_count
);
  initial
  begin
    rx_byte = 8'h00;
    rx_par = 1'b0;
    stop_ok = 1'b0;
    rx_count = 0;
  end

  // Mid-bit sampling; off during synchronous runs, zeros there are data
  always
  begin
    @(negedge clock iff (en && tx_line === 1'b0));
    repeat (BIT_CYC / 2) @(negedge clock);
    rx_byte = 8'h00;
    for (int i = 0; i < nbits; i++)
    begin
      repeat (BIT_CYC) @(negedge clock);
      rx_byte[i] = tx_line;
    end
    if (par_en)
    begin
      repeat (BIT_CYC) @(negedge clock);
      rx_par = tx_line;
    end
    repeat (BIT_CYC) @(negedge clock);
    stop_ok = tx_line;
    rx_count++;
  end
endmodule

/* verification/mlu_line_usart_bench.sv */
// Self-checking bench for the line transmit USART and its settings
`timescale 1ns/10ps
module mlu_line_usart_bench
  import mlu_pkg::*;
;
  // 24 kHz model clock gives ten-cycle bits at 2400 bps
  localparam int BIT = 10;
  localparam int BRK = 5;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata, rx_byte;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready, tx_data_ready, tx_underflow, tx_line, rx_par, stop_ok;
  logic [4:0] tx_atten_hdb, rx_atten_hdb;
  logic [3:0] rx_data_bits, line_std, result_code;
  logic rx_parity_en, rx_sync, std_reserved, cmd_return;
  logic [1:0] rx_overspeed;
  logic data_mode = 1'b1;
  logic request_to_send_pin = 1'b1;
  logic break_start = 1'b0;
  logic result_stb = 1'b0;
  logic line_break, break_done, result_valid, full_seen;
  mlu_result_e result_sel = RES_OK;
  logic [3:0] nbits = 4'h8;
  logic par_en = 1'b0, tx_pattern_en = 1'b0;
  logic rx_en = 1'b1;
  logic [15:0] sbits;
  int rx_count, n;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] addrs [6] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h00};
  logic [7:0] rstv [6] = '{8'hB0, 8'h30, 8'h00, 8'h00, 8'h1E, 8'h00};
  logic [7:0] cfgs [3] = '{8'h00, 8'h38, 8'h50};
  logic [7:0] chars [3] = '{8'h0C, 8'hA5, 8'h2C};

  always #5 clock = ~clock;

  mlu_line_usart #(.CLK_FREQ(24000), .SEC_CYC(10), .BRK_CYC(BRK))
  mlu_line_usart_i (
    .clock, .rstn, .clk_en(1'b1), .cfg_wr, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .tx_valid, .tx_data, .tx_ready, .tx_pattern_en,
    .tx_data_ready, .tx_underflow, .tx_line, .tx_atten_hdb, .rx_atten_hdb,
    .rx_data_bits, .rx_parity_en, .rx_overspeed, .rx_sync, .line_std,
    .std_reserved, .data_mode, .request_to_send_pin, .cmd_return,
    .break_start, .line_break, .break_done, .result_stb, .result_sel,
    .result_code, .result_valid
  );

  mlu_remote_rx #(.BIT_CYC(BIT)) mlu_remote_rx_i (
    .clock, .en(rx_en), .tx_line, .nbits, .par_en, .rx_byte, .rx_par,
    .stop_ok, .rx_count
  );

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clock);
    cfg_addr = a;
    @(negedge clock);
    check("cfg_rdata", exp, cfg_rdata);
  endtask

  task automatic send(logic [7:0] d);
    int k;
    k = 0;
    @(negedge clock);
    while (tx_ready !== 1'b1 && k < 2000)
    begin
      full_seen = 1'b1;
      @(negedge clock);
      k++;
    end
    tx_valid = 1'b1;
    tx_data = d;
    @(negedge clock);
    tx_valid = 1'b0;
  endtask

  task automatic get(logic [7:0] d);
    int c;
    logic [7:0] m;
    c = rx_count;
    m = 8'((9'h001 << nbits) - 9'h001);
    for (int k = 0; k < 400 && rx_count == c; k++)
      @(negedge clock);
    check("char count", 8'(c + 1), 8'(rx_count));
    check("line char", d & m, rx_byte);
    if (par_en)
      check("parity bit", {7'h00, ~^(d & m)}, {7'h00, rx_par});
    check("stop bit", 8'h01, {7'h00, stop_ok});
  endtask

  task automatic rts_run(int hold, logic [7:0] exp);
    n = 0;
    request_to_send_pin = 1'b0;
    for (int k = 0; k < 80; k++)
    begin
      if (k == hold)
        request_to_send_pin = 1'b1;
      @(negedge clock);
      n += int'(cmd_return === 1'b1);
    end
    check("cmd_return pulses", exp, 8'(n));
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++)
      rd(addrs[i], rstv[i]);
    check("tx_atten_hdb", 8'h15, 8'(tx_atten_hdb));
    check("rx_data_bits", 8'h08, 8'(rx_data_bits));
    for (int i = 0; i < 6; i++)
      wr(addrs[i], 8'hA5 ^ 8'(i));
    for (int i = 0; i < 6; i++)
      rd(addrs[i], (i < 5) ? 8'hA5 ^ 8'(i) : 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(REG_RX_CFG, {i[1:0], i[2:0], i[2:0]});
      wr(REG_TX_CFG, {5'h0E, i[2:0]});
      check("tx_atten_hdb", 8'(3 * (7 - i)), 8'(tx_atten_hdb));
      check("rx_atten_hdb", 8'(3 * (7 - i)), 8'(rx_atten_hdb));
      check("rx_data_bits", 8'(5 + i[2:1]), 8'(rx_data_bits));
      check("rx_parity_en", 8'(i[0]), 8'(rx_parity_en));
      check("rx_overspeed", 8'(i[1:0]), 8'(rx_overspeed));
      check("rx_sync", 8'(i[1:0] == 2'h3), 8'(rx_sync));
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(REG_STD, {i[3:0], 4'h0});
      check("line_std", 8'(i), 8'(line_std));
      check("std_reserved", 8'(i == 4 || i > 9), 8'(std_reserved));
    end
    wr(REG_STD, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clock);
      result_stb = 1'b1;
      result_sel = mlu_result_e'(i);
      @(negedge clock);
      result_stb = 1'b0;
      check("result_code", 8'(i), 8'(result_code));
      check("result_valid", 8'h01, {7'h00, result_valid});
    end
    for (int i = 0; i < 3; i++)
    begin
      repeat (3 * BIT) @(negedge clock);
      wr(REG_TX_CFG, cfgs[i]);
      nbits = 4'(5 + cfgs[i][5:4]);
      par_en = (cfgs[i][7:6] == 2'h0);
      fork
        send(chars[i]);
        get(chars[i]);
      join
    end
    // Overfill the FIFO while the line drains it
    repeat (3 * BIT) @(negedge clock);
    wr(REG_TX_CFG, 8'h70);
    nbits = 4'h8;
    par_en = 1'b0;
    full_seen = 1'b0;
    fork
      for (int i = 0; i < 12; i++)
        send(8'h30 + 8'(i));
      for (int i = 0; i < 12; i++)
        get(8'h30 + 8'(i));
    join
    check("fifo refused", 8'h01, {7'h00, full_seen});
    repeat (3 * BIT) @(negedge clock);
    check("tx_underflow", 8'h01, {7'h00, tx_underflow});
    check("tx_line idle", 8'h01, {7'h00, tx_line});
    check("tx_data_ready", 8'h01, {7'h00, tx_data_ready});
    fork
      begin
        send(8'h5A);
        @(negedge clock);
        check("ready after load", 8'h00, {7'h00, tx_data_ready});
        check("underflow cleared", 8'h00, {7'h00, tx_underflow});
      end
      get(8'h5A);
    join
    wr(REG_BRK, 8'h02);
    @(negedge clock);
    break_start = 1'b1;
    @(negedge clock);
    break_start = 1'b0;
    n = 0;
    while (line_break === 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    check("break length", 8'(2 * BRK + 1), 8'(n));
    wr(REG_RTS_TMO, 8'h03);
    rts_run(20, 8'h00);
    rts_run(40, 8'h02);
    wr(REG_RTS_TMO, 8'h00);
    rts_run(40, 8'h00);
    // Synchronous last: its underflow repeats data, not stop level
    repeat (3 * BIT) @(negedge clock);
    rx_en = 1'b0;
    wr(REG_TX_CFG, 8'hF0);
    send(8'h3C);
    @(negedge clock);
    n = 0;
    while (tx_data_ready !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    repeat (BIT / 2 - 1) @(negedge clock);
    for (int i = 0; i < 16; i++)
    begin
      sbits[i] = tx_line;
      repeat (BIT) @(negedge clock);
    end
    check("sync byte", 8'h3C, sbits[7:0]);
    check("sync repeat", 8'h3C, sbits[15:8]);
    check("sync underflow", 8'h01, {7'h00, tx_underflow});
    tx_pattern_en = 1'b1;
    send(8'h3C);
    repeat (20 * BIT) @(negedge clock);
    check("pattern underflow", 8'h00, {7'h00, tx_underflow});
    results();
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    fail_count++;
    results();
  end
endmodule
